// ==== core/can_timing_pkg.sv ====
// shared constants, types and register map of the can bit timing block
package can_timing_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h01;
    localparam logic [7:0] BTR0_OFFSET   = 8'h02;
    localparam logic [7:0] BTR1_OFFSET   = 8'h03;

    // control and status bit positions
    localparam int CTRL_INIT_REQ_BIT = 0;
    localparam int CTRL_CLK_SEL_BIT  = 1;
    localparam int STAT_INIT_ACK_BIT = 0;
    localparam int STAT_RX_BIT       = 1;

    // reset values: init request set so timing can be written at once
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] BTR0_RESET = 8'h00;
    localparam logic [7:0] BTR1_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // timing constants in time quanta
    localparam logic [5:0] SYNC_SEG_TQ = 6'h01;
    localparam logic [5:0] ONE_TQ      = 6'h01;

    // bit timing fields, laid out as the two registers side by side
    typedef struct packed {
        logic       triple;   // btr1 bit 7
        logic [2:0] seg2;     // btr1 bits 6-4
        logic [3:0] seg1;     // btr1 bits 3-0
        logic [1:0] jump;     // btr0 bits 7-6
        logic [5:0] presc;    // btr0 bits 5-0
    } bit_timing_type;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_FIRST,
        SEG_SECOND
    } seg_state_type;

endpackage

// ==== core/tq_divider.sv ====
// time quantum prescaler: one tick per (divisor + 1) enabled cycles
`timescale 1ns/10ps
module tq_divider
    import can_timing_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       clear_in,
    input  wire logic       enable_in,
    input  wire logic [5:0] divisor_in,
    output logic            tick_out
);

    logic [5:0] cnt_reg;
    logic [6:0] en_seen_reg;
    logic       seen_reg;

    // prescale counter; clear holds it while timing is reprogrammed
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            cnt_reg  <= '0;
            tick_out <= 1'b0;
        end else if (enable_in) begin
            if (cnt_reg == divisor_in) begin
                cnt_reg  <= '0;
                tick_out <= 1'b1;
            end else begin
                cnt_reg  <= cnt_reg + 6'h01;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

    // helper: enabled cycles between two ticks, for the spacing check
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            en_seen_reg <= '0;
            seen_reg    <= 1'b0;
        end else if (tick_out) begin
            en_seen_reg <= {6'h00, enable_in};
            seen_reg    <= 1'b1;
        end else begin
            en_seen_reg <= en_seen_reg + {6'h00, enable_in};
        end
    end

    chk_tick_spacing: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (tick_out && seen_reg && !clear_in)
            |-> en_seen_reg == ({1'b0, divisor_in} + 7'h01))
        else $error("quantum tick spacing differs from prescale");

    chk_tick_source: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        tick_out |-> $past(enable_in))
        else $error("quantum tick without a can clock edge");

endmodule

// ==== core/can_bit_timing.sv ====
// can bit timing: timing registers, segment sequencer and bus sampling
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module can_bit_timing
    import can_timing_pkg::*;
(
    input  wire logic              CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              OSC_TICK_IN,
    input  wire logic              CAN_RX_IN,
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [DATA_W-1:0] WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [DATA_W-1:0] RDATA_OUT,
    output logic                   INIT_ACK_OUT,
    output logic                   TQ_TICK_OUT,
    output logic                   BIT_START_OUT,
    output logic                   SAMPLE_POINT_OUT,
    output logic                   RX_BIT_OUT
);

    bit_timing_type timing_reg;
    seg_state_type  state_reg;
    logic           init_req_reg;
    logic           clk_sel_reg;
    logic           init_active;
    logic           can_clk_en;
    logic           tq_tick;
    logic [5:0]     tq_cnt_reg;
    logic [2:0]     ext_reg;
    logic [2:0]     shorten_reg;
    logic           resynced_reg;
    logic           last_rx_reg;
    logic [1:0]     hist_reg;
    logic [5:0]     seg1_len;
    logic [5:0]     seg2_len;
    logic [2:0]     jump_len;
    logic [5:0]     seg1_end;
    logic [5:0]     seg2_end;
    logic           edge_seen;
    logic           majority;
    logic [6:0]     bit_tq_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // register port

    assign init_active = init_req_reg && INIT_ACK_OUT;

    // request is writable anytime; clock select only in init mode
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            init_req_reg <= CTRL_RESET[CTRL_INIT_REQ_BIT];
            clk_sel_reg  <= CTRL_RESET[CTRL_CLK_SEL_BIT];
        end else if (WR_IN && ADDR_IN == CTRL_OFFSET) begin
            init_req_reg <= WDATA_IN[CTRL_INIT_REQ_BIT];
            if (init_active) begin
                clk_sel_reg <= WDATA_IN[CTRL_CLK_SEL_BIT];
            end
        end
    end

    // acknowledge follows the request one cycle later (handshake)
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            INIT_ACK_OUT <= CTRL_RESET[CTRL_INIT_REQ_BIT];
        end else begin
            INIT_ACK_OUT <= init_req_reg;
        end
    end

    // timing writes outside init mode are dropped silently
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            timing_reg <= {BTR1_RESET, BTR0_RESET};
        end else if (WR_IN && init_active) begin
            if (ADDR_IN == BTR0_OFFSET) begin
                timing_reg[7:0] <= WDATA_IN;
            end
            if (ADDR_IN == BTR1_OFFSET) begin
                timing_reg[15:8] <= WDATA_IN;
            end
        end
    end

    // read data in the cycle after the strobe; unmapped reads as zero
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !RD_IN) begin
            RDATA_OUT <= READ_ZERO;
        end else begin
            case (ADDR_IN)
                CTRL_OFFSET: begin
                    RDATA_OUT <= {6'h00, clk_sel_reg, init_req_reg};
                end
                STATUS_OFFSET: begin
                    RDATA_OUT <= {6'h00, RX_BIT_OUT, INIT_ACK_OUT};
                end
                BTR0_OFFSET: RDATA_OUT <= timing_reg[7:0];
                BTR1_OFFSET: RDATA_OUT <= timing_reg[15:8];
                default:     RDATA_OUT <= READ_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // quantum clock

    assign can_clk_en = clk_sel_reg ? 1'b1 : OSC_TICK_IN;

    tq_divider u_divider (
        .clk_in     (CLK_IN),
        .rst_n_in   (RST_N_IN),
        .clear_in   (init_active),
        .enable_in  (can_clk_en),
        .divisor_in (timing_reg.presc),
        .tick_out   (tq_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // segment sequencer

    // segment lengths in quanta, adjusted by the current resync
    assign seg1_len  = {2'b00, timing_reg.seg1} + ONE_TQ;
    assign seg2_len  = {3'b000, timing_reg.seg2} + ONE_TQ;
    assign jump_len  = {1'b0, timing_reg.jump} + 3'h1;
    assign seg1_end  = seg1_len + {3'b000, ext_reg} - ONE_TQ;
    assign seg2_end  = seg2_len - {3'b000, shorten_reg} - ONE_TQ;
    // recessive to dominant edge seen on a quantum boundary
    assign edge_seen = last_rx_reg && !CAN_RX_IN && !resynced_reg;
    assign majority  = (hist_reg[1] & hist_reg[0])
                     | (hist_reg[1] & CAN_RX_IN)
                     | (hist_reg[0] & CAN_RX_IN);

    // one resync per bit keeps a glitchy bus from stretching a bit twice
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || init_active) begin
            state_reg    <= SEG_SYNC;
            tq_cnt_reg   <= '0;
            ext_reg      <= '0;
            shorten_reg  <= '0;
            resynced_reg <= 1'b1;
        end else if (tq_tick) begin
            case (state_reg)
                SEG_SYNC: begin
                    state_reg    <= SEG_FIRST;
                    tq_cnt_reg   <= '0;
                    ext_reg      <= '0;
                    shorten_reg  <= '0;
                    resynced_reg <= 1'b0;
                end
                SEG_FIRST: begin
                    if (tq_cnt_reg == seg1_end) begin
                        state_reg  <= SEG_SECOND;
                        tq_cnt_reg <= '0;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + ONE_TQ;
                    end
                    if (edge_seen) begin // late edge lengthens
                        resynced_reg <= 1'b1;
                        ext_reg <= (tq_cnt_reg + ONE_TQ > {3'b000, jump_len})
                                 ? jump_len : tq_cnt_reg[2:0] + 3'h1;
                    end
                end
                SEG_SECOND: begin
                    if (edge_seen && seg2_end - tq_cnt_reg
                        <= {3'b000, jump_len}) begin // early edge
                        state_reg    <= SEG_FIRST;
                        tq_cnt_reg   <= '0;
                        ext_reg      <= '0;
                        resynced_reg <= 1'b1;
                    end else if (edge_seen) begin
                        shorten_reg  <= jump_len;
                        resynced_reg <= 1'b1;
                        tq_cnt_reg   <= tq_cnt_reg + ONE_TQ;
                    end else if (tq_cnt_reg >= seg2_end) begin
                        state_reg  <= SEG_SYNC;
                        tq_cnt_reg <= '0;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + ONE_TQ;
                    end
                end
                default: state_reg <= SEG_SYNC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus sampling and outputs

    // bus level history at each quantum boundary
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            last_rx_reg <= 1'b1;
            hist_reg    <= 2'b11;
        end else if (tq_tick) begin
            last_rx_reg <= CAN_RX_IN;
            hist_reg    <= {hist_reg[0], CAN_RX_IN};
        end
    end

    // received bit taken at the end of the first segment
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            RX_BIT_OUT       <= 1'b1;
            SAMPLE_POINT_OUT <= 1'b0;
        end else begin
            SAMPLE_POINT_OUT <= 1'b0;
            if (tq_tick && !init_active && state_reg == SEG_FIRST
                && tq_cnt_reg == seg1_end) begin
                SAMPLE_POINT_OUT <= 1'b1;
                RX_BIT_OUT <= timing_reg.triple ? majority
                                                : CAN_RX_IN;
            end
        end
    end

    // quantum tick and bit start mirrored to the pins
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            TQ_TICK_OUT   <= 1'b0;
            BIT_START_OUT <= 1'b0;
        end else begin
            TQ_TICK_OUT   <= tq_tick && !init_active;
            BIT_START_OUT <= tq_tick && !init_active
                             && state_reg == SEG_SYNC;
        end
    end

    // helper: quanta per bit, for the bit length check
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || init_active) begin
            bit_tq_cnt_reg <= '0;
        end else if (tq_tick) begin
            bit_tq_cnt_reg <= (state_reg == SEG_SYNC) ? 7'h01
                                                      : bit_tq_cnt_reg + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_timing_write_gate: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        (WR_IN && !init_active) |=> $stable(timing_reg))
        else $error("timing changed outside init mode");

    chk_init_handshake: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        $rose(init_req_reg) |=> INIT_ACK_OUT)
        else $error("init acknowledge did not follow request");

    chk_bit_length: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        (tq_tick && !init_active && state_reg == SEG_SYNC && !resynced_reg)
            |-> bit_tq_cnt_reg == {1'b0, SYNC_SEG_TQ + seg1_len + seg2_len})
        else $error("nominal bit length wrong");

    chk_sync_segment: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN || init_active)
        (tq_tick && state_reg == SEG_SYNC) |=> state_reg == SEG_FIRST)
        else $error("sync segment longer than one quantum");

    chk_single_sample: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        (SAMPLE_POINT_OUT && !timing_reg.triple)
            |-> RX_BIT_OUT == $past(CAN_RX_IN))
        else $error("single sample does not match bus");

    chk_majority_vote: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        (SAMPLE_POINT_OUT && timing_reg.triple)
            |-> RX_BIT_OUT == $past(majority))
        else $error("triple sample vote wrong");

    chk_jump_bound: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        ext_reg <= jump_len && shorten_reg <= jump_len)
        else $error("resync adjustment beyond jump width");

    chk_osc_source: assert property (@(posedge CLK_IN)
        disable iff (!RST_N_IN)
        (!clk_sel_reg && !OSC_TICK_IN) |=> !tq_tick)
        else $error("quantum tick without oscillator tick");

    cov_triple_sample: cover property (@(posedge CLK_IN)
        SAMPLE_POINT_OUT && timing_reg.triple);
    cov_lengthen: cover property (@(posedge CLK_IN)
        ext_reg != 3'h0);
    cov_shorten: cover property (@(posedge CLK_IN)
        shorten_reg != 3'h0);

endmodule

// ==== test/can_bus_node.sv ====
// behavioural can bus node that drives the receive line of the block
`timescale 1ns/10ps
module can_bus_node (
    input  wire logic clk_in,
    output logic      rx_out
);

    ////////////////////////////////////////////////////////////////////////////
    // the bus idles recessive: the pull-up wins while no node drives it
    initial rx_out = 1'b1;

    // hold a level for a number of bus clock cycles, changed after an edge
    task automatic drive(input logic level, input int cycles);
        @(posedge clk_in);
        rx_out <= level;
        repeat (cycles - 1) @(posedge clk_in);
    endtask

endmodule

// ==== test/test_can_bit_timing_config.sv ====
// self-checking testbench for the can bit timing block
`timescale 1ns/10ps
module test_can_bit_timing_config
    import can_timing_pkg::*;
;

    // cycle ceiling: the whole run needs a few thousand cycles
    localparam int LIMIT = 20000;
    // timing table: prescale and jump, segments, clock select per entry
    localparam logic [7:0] CFG0 [4] = '{8'hc0, 8'h42, 8'h81, 8'h3f};
    localparam logic [7:0] CFG1 [4] = '{8'h13, 8'h7f, 8'h24, 8'h93};
    localparam logic [3:0] CFG_SEL  = 4'hb;
    // resync table: cycles from bit start to the edge, expected bit quanta
    // late edge at seg1 quantum 3, early edges at seg2 quanta 1 and 2
    localparam int RS_WAIT [3] = '{9, 29, 33};
    localparam int RS_TQ   [3] = '{15, 11, 23};

    logic              clk      = 1'b0;
    logic              rst_n    = 1'b0;
    logic              osc_tick = 1'b0;
    logic [ADDR_W-1:0] addr     = 8'h00;
    logic [DATA_W-1:0] wdata    = 8'h00;
    logic              wr       = 1'b0;
    logic              rd       = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              init_ack;
    logic              tq_tick;
    logic              bit_start;
    logic              sample_pt;
    logic              rx_bit;
    logic              can_rx;
    logic [2:0]        pulses;
    int                n_errors = 0;
    int                checks   = 0;
    int                cycles   = 0;

`define CMP(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

    ////////////////////////////////////////////////////////////////////////////
    can_bit_timing uut (
        .CLK_IN           (clk),
        .RST_N_IN         (rst_n),
        .OSC_TICK_IN      (osc_tick),
        .CAN_RX_IN        (can_rx),
        .ADDR_IN          (addr),
        .WDATA_IN         (wdata),
        .WR_IN            (wr),
        .RD_IN            (rd),
        .RDATA_OUT        (rdata),
        .INIT_ACK_OUT     (init_ack),
        .TQ_TICK_OUT      (tq_tick),
        .BIT_START_OUT    (bit_start),
        .SAMPLE_POINT_OUT (sample_pt),
        .RX_BIT_OUT       (rx_bit)
    );

    can_bus_node node (
        .clk_in (clk),
        .rx_out (can_rx)
    );

    // pulse outputs gathered so one wait task serves all three
    assign pulses = {sample_pt, bit_start, tq_tick};

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock; oscillator enable on every second cycle
    always #20 clk = ~clk;

    always @(posedge clk) osc_tick <= ~osc_tick;

    // hang guard: a run that overstays counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, sampled mid-cycle
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        `CMP(rdata, e)
    endtask

    // cycles until the chosen pulse is seen, bounded so a dead block ends
    task automatic wait_pulse(input int a, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pulses[a] !== 1'b1 && n < 3000);
    endtask

    // timing may only change in init mode, and select only there too
    task automatic configure(input logic [7:0] b0, input logic [7:0] b1,
                             input logic sel);
        reg_write(CTRL_OFFSET, {6'h00, sel, 1'b1});
        repeat (2) @(posedge clk);
        reg_write(BTR0_OFFSET, b0);
        reg_write(BTR1_OFFSET, b1);
        reg_write(CTRL_OFFSET, {6'h00, sel, 1'b1});
        reg_write(CTRL_OFFSET, {6'h00, sel, 1'b0});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int   n;
        int   p;
        logic exp_rx;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CMP(init_ack, 1'b1)
        `CMP(tq_tick, 1'b0)
        expect_reg(CTRL_OFFSET, CTRL_RESET);
        expect_reg(STATUS_OFFSET, 8'h03);
        expect_reg(BTR0_OFFSET, BTR0_RESET);
        expect_reg(BTR1_OFFSET, BTR1_RESET);
        expect_reg(8'h04, READ_ZERO);
        reg_write(BTR0_OFFSET, 8'h5a);
        reg_write(BTR1_OFFSET, 8'ha5);
        expect_reg(BTR0_OFFSET, 8'h5a);
        expect_reg(BTR1_OFFSET, 8'ha5);
        $display("test register access done");

        // leave init mode, then timing and select must be locked
        reg_write(CTRL_OFFSET, 8'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CMP(init_ack, 1'b0)
        reg_write(BTR0_OFFSET, 8'hff);
        reg_write(BTR1_OFFSET, 8'h00);
        reg_write(CTRL_OFFSET, 8'h02);
        expect_reg(BTR0_OFFSET, 8'h5a);
        expect_reg(BTR1_OFFSET, 8'ha5);
        expect_reg(CTRL_OFFSET, 8'h00);
        expect_reg(STATUS_OFFSET, 8'h02);
        $display("test write lock done");

        // quantum, bit and sample point lengths over the timing table
        for (int i = 0; i < 4; i++) begin
            configure(CFG0[i], CFG1[i], CFG_SEL[i]);
            p = (CFG0[i][5:0] + 1) * (CFG_SEL[i] ? 1 : 2);
            wait_pulse(0, n);
            wait_pulse(0, n);
            `CMP(n, p)
            wait_pulse(1, n);
            wait_pulse(1, n);
            `CMP(n, p * (3 + CFG1[i][3:0] + CFG1[i][6:4]))
            wait_pulse(1, n);
            wait_pulse(2, n);
            `CMP(n, p * (1 + CFG1[i][3:0]))
        end
        $display("test bit timing done");

        // one-quantum recessive glitch on a dominant bus at the sample point
        for (int t = 0; t < 2; t++) begin
            configure(8'h03, {t[0], 7'h13}, 1'b1);
            node.drive(1'b0, 1);
            wait_pulse(2, n);
            wait_pulse(2, n);
            `CMP(rx_bit, 1'b0)
            fork
                begin
                    repeat (24) @(posedge clk);
                    node.drive(1'b1, 4);
                    node.drive(1'b0, 1);
                end
            join_none
            wait_pulse(2, n);
            exp_rx = ~t[0];
            `CMP(rx_bit, exp_rx)
            expect_reg(STATUS_OFFSET, {6'h00, exp_rx, 1'b0});
            wait fork;
            node.drive(1'b1, 1);
        end
        $display("test sampling done");

        // resync: late edge lengthens, early edges shorten or restart
        // prescale 4, jump 2, seg1 8, seg2 4: a plain bit is 13 quanta
        configure(8'h43, 8'h37, 1'b1);
        wait_pulse(1, n);
        for (int k = 0; k < 3; k++) begin
            p = RS_WAIT[k];
            fork
                begin
                    repeat (p) @(posedge clk);
                    if (p > RS_WAIT[0]) begin
                        node.drive(1'b1, 4);
                    end
                    node.drive(1'b0, 1);
                end
            join_none
            wait_pulse(1, n);
            `CMP(n, 4 * RS_TQ[k])
            wait fork;
        end
        $display("test resync done");
        complete_run();
    end

endmodule
